// File: pkg/afr_pkg.sv
// package: register offset, field positions and pin-select codes for the remap block
package afr_pkg;
	localparam logic [3:0] AFR_OFF_REMAP = 4'h4;
	localparam logic [31:0] AFR_RESET_VAL = 32'h0000_0000;
	localparam int AFR_DBG_LSB = 24;
	localparam int AFR_DBG_MSB = 26;
	localparam int AFR_T1SRC_BIT = 23;
	localparam int AFR_I2C_HI_BIT = 22;
	localparam int AFR_SER_HI_BIT = 21;
	localparam int AFR_ADC_REG_BIT = 18;
	localparam int AFR_ADC_INJ_BIT = 17;
	localparam int AFR_XTAL_BIT = 15;
	localparam int AFR_T2_LSB = 8;
	localparam int AFR_T2_MSB = 9;
	localparam int AFR_T1_LSB = 6;
	localparam int AFR_T1_MSB = 7;
	localparam int AFR_SER_LO_BIT = 2;
	localparam int AFR_I2C_LO_BIT = 1;
	localparam int AFR_SPI_BIT = 0;
	// readable bits: 23..21, 18, 17, 15, 9..6, 2..0; debug field is write-only
	localparam logic [31:0] AFR_READ_MASK = 32'h00e6_83c7;
	localparam logic [31:0] AFR_WRITE_MASK = 32'h07e6_83c7;
	localparam logic [2:0] AFR_DBG_OFF_CODE = 3'h4;
	typedef enum logic [1:0] {AFR_I2C_DEFAULT, AFR_I2C_ALT1, AFR_I2C_ALT2} afr_i2c_map_t;
	typedef enum logic {AFR_ADC_PIN_PD3, AFR_ADC_PIN_PC2} afr_adc_pin_t;
endpackage : afr_pkg

// File: hdl/afr_wb_slave.sv
// file: classic wishbone slave front end that decodes one-word register accesses
`timescale 1ns/1ps
module afr_wb_slave (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	output logic wb_ack_o,
	output logic wb_err_o,
	// decoded strobes
	output logic hit_wr,
	output logic hit_rd
);
	import afr_pkg::*;
	typedef struct packed {
		logic ack;
		logic err;
	} afr_wb_state_t;
	afr_wb_state_t s_r, s_nxt;
	logic req;
	logic ok;
	always_comb begin
		req = wb_cyc_i && wb_stb_i && !s_r.ack && !s_r.err;
		// only full word accesses to the one register are accepted
		ok = (wb_adr_i == AFR_OFF_REMAP) && (wb_sel_i == 4'hf);
		s_nxt.ack = req && ok;
		s_nxt.err = req && !ok;
		hit_wr = req && ok && wb_we_i;
		hit_rd = req && ok && !wb_we_i;
	end
	always_ff @(posedge core_clk) begin
		if (reset) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
	assign wb_ack_o = s_r.ack;
	assign wb_err_o = s_r.err;
endmodule : afr_wb_slave

// File: hdl/afr_remap.sv
// file: pin remap configuration register and the pin selects it drives
//
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module afr_remap (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	// pin selects
	output logic debug_serial_interface_en,
	output logic timer1_ch1_source_sel,
	output afr_pkg::afr_i2c_map_t i2c_map,
	output logic [1:0] serial_map,
	output afr_pkg::afr_adc_pin_t adc_regular_trigger_pin_sel,
	output afr_pkg::afr_adc_pin_t adc_injected_trigger_pin_sel,
	output logic crystal_pin_release,
	output logic [1:0] timer2_map_sel,
	output logic [1:0] timer1_map_sel,
	output logic spi_map_sel
);
	import afr_pkg::*;
	typedef struct packed {
		logic [31:0] cfg;
		logic [31:0] rdata;
		logic dbg_en;
		afr_i2c_map_t i2c;
	} afr_state_t;
	afr_state_t s_r, s_nxt;
	logic hit_wr;
	logic hit_rd;
	logic [2:0] dbg_code;
	afr_wb_slave u_wb (
		.core_clk(core_clk),
		.reset(reset),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_ack_o(wb_ack_o),
		.wb_err_o(wb_err_o),
		.hit_wr(hit_wr),
		.hit_rd(hit_rd)
	);
	always_comb begin
		s_nxt = s_r;
		dbg_code = wb_dat_i[AFR_DBG_MSB:AFR_DBG_LSB];
		if (hit_wr) begin
			s_nxt.cfg = wb_dat_i & AFR_WRITE_MASK;
			// codes other than 0xx and 100 leave the debug state alone
			if (!dbg_code[2]) begin
				s_nxt.dbg_en = 1'b1;
			end else if (dbg_code == AFR_DBG_OFF_CODE) begin
				s_nxt.dbg_en = 1'b0;
			end
		end
		// write-only debug field reads zero via the read mask
		s_nxt.rdata = hit_rd ? (s_r.cfg & AFR_READ_MASK) : '0;
		// i2c map is decoded ahead so the pin select leaves a flop
		case ({s_nxt.cfg[AFR_I2C_HI_BIT], s_nxt.cfg[AFR_I2C_LO_BIT]})
			2'h0: s_nxt.i2c = AFR_I2C_DEFAULT;
			2'h1: s_nxt.i2c = AFR_I2C_ALT1;
			default: s_nxt.i2c = AFR_I2C_ALT2;
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (reset) begin
			s_r.cfg <= AFR_RESET_VAL;
			s_r.rdata <= '0;
			s_r.dbg_en <= 1'b1;
			s_r.i2c <= AFR_I2C_DEFAULT;
		end else begin
			s_r <= s_nxt;
		end
	end
	always_comb begin
		wb_dat_o = s_r.rdata;
		debug_serial_interface_en = s_r.dbg_en;
		timer1_ch1_source_sel = s_r.cfg[AFR_T1SRC_BIT];
		i2c_map = s_r.i2c;
		serial_map = {s_r.cfg[AFR_SER_HI_BIT], s_r.cfg[AFR_SER_LO_BIT]};
		adc_regular_trigger_pin_sel = afr_adc_pin_t'(s_r.cfg[AFR_ADC_REG_BIT]);
		adc_injected_trigger_pin_sel = afr_adc_pin_t'(s_r.cfg[AFR_ADC_INJ_BIT]);
		crystal_pin_release = s_r.cfg[AFR_XTAL_BIT];
		timer2_map_sel = s_r.cfg[AFR_T2_MSB:AFR_T2_LSB];
		timer1_map_sel = s_r.cfg[AFR_T1_MSB:AFR_T1_LSB];
		spi_map_sel = s_r.cfg[AFR_SPI_BIT];
	end

	chk_reset_debug_on: assert property (@(posedge core_clk) reset |=> debug_serial_interface_en)
		else $error("debug port not enabled after reset");
	chk_debug_off_code: assert property (@(posedge core_clk) disable iff (reset)
		hit_wr && wb_dat_i[AFR_DBG_MSB:AFR_DBG_LSB] == AFR_DBG_OFF_CODE |=> !debug_serial_interface_en)
		else $error("debug not disabled by code 100");
	chk_debug_keep_code: assert property (@(posedge core_clk) disable iff (reset)
		hit_wr && wb_dat_i[AFR_DBG_MSB] && wb_dat_i[AFR_DBG_MSB-1:AFR_DBG_LSB] != 2'h0
		|=> $stable(debug_serial_interface_en))
		else $error("invalid debug code changed debug state");
	chk_t1src_write: assert property (@(posedge core_clk) disable iff (reset)
		hit_wr |=> timer1_ch1_source_sel == $past(wb_dat_i[AFR_T1SRC_BIT]))
		else $error("timer1 source select not written");
	chk_i2c_alt2: assert property (@(posedge core_clk) disable iff (reset)
		s_r.cfg[AFR_I2C_HI_BIT] |-> i2c_map == AFR_I2C_ALT2)
		else $error("i2c high bit does not select second alternate");
	chk_serial_write: assert property (@(posedge core_clk) disable iff (reset)
		hit_wr |=> serial_map == {$past(wb_dat_i[AFR_SER_HI_BIT]), $past(wb_dat_i[AFR_SER_LO_BIT])})
		else $error("serial map not formed from high and low bits");
	chk_adc_sel: assert property (@(posedge core_clk) disable iff (reset)
		hit_wr |=> adc_injected_trigger_pin_sel == afr_adc_pin_t'($past(wb_dat_i[AFR_ADC_INJ_BIT])))
		else $error("adc injected select not written");
	chk_adc_regular: assert property (@(posedge core_clk) disable iff (reset)
		hit_wr |=> adc_regular_trigger_pin_sel == afr_adc_pin_t'($past(wb_dat_i[AFR_ADC_REG_BIT])))
		else $error("adc regular select not written");
	chk_i2c_alt1: assert property (@(posedge core_clk) disable iff (reset)
		!s_r.cfg[AFR_I2C_HI_BIT] && s_r.cfg[AFR_I2C_LO_BIT] |-> i2c_map == AFR_I2C_ALT1)
		else $error("i2c low bit does not select first alternate");
	chk_ack_single: assert property (@(posedge core_clk) disable iff (reset)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	chk_xtal_write: assert property (@(posedge core_clk) disable iff (reset)
		hit_wr |=> crystal_pin_release == $past(wb_dat_i[AFR_XTAL_BIT]))
		else $error("crystal release not written");
	chk_t2_readback: assert property (@(posedge core_clk) disable iff (reset)
		hit_rd |=> wb_dat_o[AFR_T2_MSB:AFR_T2_LSB] == timer2_map_sel && wb_ack_o)
		else $error("timer2 field read back wrong");
	chk_reserved_zero: assert property (@(posedge core_clk) disable iff (reset)
		(wb_dat_o & ~AFR_READ_MASK) == '0)
		else $error("reserved or write-only bits read nonzero");
	chk_sel_refused: assert property (@(posedge core_clk) disable iff (reset)
		wb_cyc_i && wb_stb_i && wb_sel_i != 4'hf && !wb_ack_o && !wb_err_o |=> wb_err_o && !wb_ack_o)
		else $error("partial word access not refused");
endmodule : afr_remap

// File: dv/tb_afr_remap.sv
// testbench: register access and pin-select checks for the remap block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_afr_remap;
	import afr_pkg::*;
	logic core_clk = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [3:0] adr = 4'h0, sel = 4'h0;
	logic [31:0] wdat = 32'h0, q, d, dat_o;
	logic ack, err, dbg_en, t1src, xtal, spi, e, prev, x;
	afr_i2c_map_t i2c;
	afr_adc_pin_t adc_reg, adc_inj;
	logic [1:0] ser, t2, t1, i;
	int n_mismatch = 0, n_checks = 0;
	afr_remap dut (.core_clk(core_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .wb_err_o(err), .debug_serial_interface_en(dbg_en),
		.timer1_ch1_source_sel(t1src), .i2c_map(i2c), .serial_map(ser),
		.adc_regular_trigger_pin_sel(adc_reg), .adc_injected_trigger_pin_sel(adc_inj),
		.crystal_pin_release(xtal), .timer2_map_sel(t2), .timer1_map_sel(t1), .spi_map_sel(spi));
	initial forever #10 core_clk = ~core_clk;
	task automatic final_report;
		if (n_mismatch == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report
	task automatic rst(input int n);
		reset <= 1'b1;
		repeat (n) @(posedge core_clk);
		reset <= 1'b0;
	endtask : rst
	// one access; held until ack or err is sampled, then released for an idle cycle
	task automatic xfer(input logic w, input logic [3:0] a, input logic [3:0] s,
		input logic [31:0] dd);
		int n;
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= dd;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
		q = dat_o;
		e = err;
		if (ack !== 1'b1 && err !== 1'b1)
			n_mismatch++;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : xfer
	initial begin
		rst(16);
		xfer(1'b0, AFR_OFF_REMAP, 4'hf, 32'h0);
		`CHK("reset read", 32'h0, q)
		`CHK("debug after reset", 1'b1, dbg_en)
		xfer(1'b1, AFR_OFF_REMAP, 4'hf, 32'hffff_ffff);
		`CHK("debug code 111", 1'b1, dbg_en)
		xfer(1'b0, AFR_OFF_REMAP, 4'hf, 32'h0);
		`CHK("all ones read", 32'h00e6_83c7, q)
		for (int k = 0; k < 4; k++) begin
			i = k[1:0];
			d = {8'h0, i[0], i[1], i[1], 2'b0, i[1], i[0], 1'b0, i[0], 5'h0, i, i, 3'h0,
				i[0], i[0], i[1]};
			xfer(1'b1, AFR_OFF_REMAP, 4'hf, d);
			`CHK("t1 source", i[0], t1src)
			`CHK("i2c map", (i[1] ? 2'd2 : {1'b0, i[0]}), i2c)
			`CHK("serial map", i, ser)
			`CHK("adc regular", i[1], adc_reg)
			`CHK("adc injected", i[0], adc_inj)
			`CHK("crystal", i[0], xtal)
			`CHK("timer2 map", i, t2)
			`CHK("timer1 map", i, t1)
			`CHK("spi map", i[1], spi)
			xfer(1'b0, AFR_OFF_REMAP, 4'hf, 32'h0);
			`CHK("field read", d, q)
		end
		// invalid codes must not bring the debug port back
		prev = 1'b1;
		for (int c = 0; c < 8; c++) begin
			xfer(1'b1, AFR_OFF_REMAP, 4'hf, {5'h0, c[2:0], 24'h0});
			x = (c < 4) ? 1'b1 : ((c == 4) ? 1'b0 : prev);
			`CHK("debug code", x, dbg_en)
			prev = x;
		end
		xfer(1'b1, 4'h8, 4'hf, 32'hffff_ffff);
		`CHK("unmapped err", 1'b1, e)
		xfer(1'b1, AFR_OFF_REMAP, 4'h3, 32'hffff_ffff);
		`CHK("partial err", 1'b1, e)
		xfer(1'b0, AFR_OFF_REMAP, 4'hf, 32'h0);
		`CHK("refused no write", 32'h0, q)
		xfer(1'b1, AFR_OFF_REMAP, 4'hf, 32'h0400_0300);
		`CHK("debug off before rerun", 1'b0, dbg_en)
		`CHK("timer2 before rerun", 2'h3, t2)
		rst(2);
		`CHK("timer2 after rerun", 2'h0, t2)
		`CHK("debug after rerun", 1'b1, dbg_en)
		xfer(1'b0, AFR_OFF_REMAP, 4'hf, 32'h0);
		`CHK("read after rerun", 32'h0, q)
		final_report();
	end
	initial begin
		repeat (3000) @(posedge core_clk);
		n_mismatch++;
		final_report();
	end
endmodule : tb_afr_remap
